// [rtl/lxcs_defs.svh]
`ifndef LXCS_DEFS_SVH
`define LXCS_DEFS_SVH

// system clock and derived timing
`define LXCS_CLK_HZ 40000000
`define LXCS_CLK_PERIOD_NS 25
`define LXCS_RESET_TIME_MS 32
`define LXCS_HWRST_TIME_NS 200
// least hold of the hardware reset request, rounded up to whole cycles
`define LXCS_HWRST_CYCLES ((`LXCS_HWRST_TIME_NS + `LXCS_CLK_PERIOD_NS - 1) / `LXCS_CLK_PERIOD_NS)
`define LXCS_RESET_CYCLES (`LXCS_RESET_TIME_MS * (`LXCS_CLK_HZ / 1000))

// serial word layout
`define LXCS_BYTE_BITS 8
`define LXCS_CMD_RW_BIT 1
`define LXCS_CMD_A4_BIT 4
`define LXCS_BIT_LAST 3'h7

// control register fields and reset value
`define LXCS_CTRL_NEAR 0
`define LXCS_CTRL_FAR 1
`define LXCS_CTRL_MARKS 2
`define LXCS_CTRL_RESET 8'h00

// calibration edge count that marks a path calibrated
`define LXCS_CAL_EDGES 16'h0100

// synchroniser lanes
`define LXCS_SY_WIDTH 18
`define LXCS_SY_SCLK 0
`define LXCS_SY_CS_N 1
`define LXCS_SY_SDI 2
`define LXCS_SY_EDGE 3
`define LXCS_SY_FAR 4
`define LXCS_SY_NEAR 5
`define LXCS_SY_MARKS 6
`define LXCS_SY_TRANSMIT_CLOCK 7
`define LXCS_SY_RCLK 8
`define LXCS_SY_XTAL 9
`define LXCS_SY_MCLK 10
`define LXCS_SY_XTAL_OK 11
`define LXCS_SY_PWR 12
`define LXCS_SY_MODE 13
`define LXCS_SY_TXP 14
`define LXCS_SY_TXN 15
`define LXCS_SY_RXP 16
`define LXCS_SY_RXN 17

`endif

// [rtl/lxcs_pkg.sv]
package lxcs_pkg;
  typedef enum logic [1:0]
  {
    LXCS_SP_IDLE = 2'b00,
    LXCS_SP_CMD = 2'b01,
    LXCS_SP_DATA = 2'b10,
    LXCS_SP_SKIP = 2'b11
  } lxcs_sport_e;
  typedef logic [7:0] lxcs_byte_t;
endpackage

// [rtl/lxcs_sync.sv]
`timescale 1ns/1ps
module lxcs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // lxcs_sync

// [rtl/lxcs_ctrl.sv]
`timescale 1ns/1ps
`include "lxcs_defs.svh"
// Summary of operation
// - serial input bits are taken on each rising serial clock edge
// - serial output valid at rising edge if edge_select high, else falling edge
// - serial output released during writes and while chip select is high
// - hardware mode: far loopback follows its input pin while high
// - hardware mode: near loopback follows its input pin while high
// - host mode: recovered data valid on falling clock if edge_select high
// - send_all_marks sends marks each transmit clock, ignoring transmit data
// - send_all_marks is suppressed while far loopback is active
// - power-up release starts a 32 ms calibration reset cycle
// - transmit delay line calibrates against the transmit clock
// - receive path calibrates from crystal, or master clock if crystal absent
// - host write setting both loopback bits is a reset command
// - reset starts when the combined request is removed
// - commanded reset clears all registers to zero, then calibration starts
// - serial word is command/address byte then data byte, 16 bits
// - device answers only when command bit A4 is set
// - command bit 1 high means read, low means write
module lxcs_ctrl #(
  parameter int unsigned RESET_CYCLES = `LXCS_RESET_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_power_good,
  input wire logic i_mode,
  input wire logic i_sclk,
  input wire logic i_chip_sel_n,
  input wire logic i_serial_in,
  input wire logic i_edge_select,
  input wire logic i_far_loopback,
  input wire logic i_near_loopback,
  input wire logic i_send_all_marks,
  input wire logic i_transmit_clock,
  input wire logic i_tx_plus_data,
  input wire logic i_tx_minus_data,
  input wire logic i_rx_clock,
  input wire logic i_rx_plus_data,
  input wire logic i_rx_minus_data,
  input wire logic i_xtal_clock,
  input wire logic i_master_clock,
  input wire logic i_xtal_present,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output lxcs_pkg::lxcs_sport_e o_port_phase,
  output logic o_line_plus,
  output logic o_line_minus,
  output logic o_rx_plus_data,
  output logic o_rx_minus_data,
  output logic o_far_loop_active,
  output logic o_near_loop_active,
  output logic o_reset_busy,
  output logic o_tx_cal_done,
  output logic o_rx_cal_done,
  output logic o_rx_ref_xtal
);
  import lxcs_pkg::*;

  logic [`LXCS_SY_WIDTH-1:0] sy;
  logic [`LXCS_SY_WIDTH-1:0] sy_prev;

  lxcs_sync #(.W(`LXCS_SY_WIDTH)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_d({i_rx_minus_data, i_rx_plus_data, i_tx_minus_data, i_tx_plus_data, i_mode,
          i_power_good, i_xtal_present, i_master_clock, i_xtal_clock, i_rx_clock,
          i_transmit_clock, i_send_all_marks, i_near_loopback, i_far_loopback,
          i_edge_select, i_serial_in, i_chip_sel_n, i_sclk}),
    .o_q(sy)
  );

  function automatic logic rose(input logic [`LXCS_SY_WIDTH-1:0] cur,
                                input logic [`LXCS_SY_WIDTH-1:0] old, input int idx);
    return cur[idx] && !old[idx];
  endfunction

  function automatic logic fell(input logic [`LXCS_SY_WIDTH-1:0] cur,
                                input logic [`LXCS_SY_WIDTH-1:0] old, input int idx);
    return !cur[idx] && old[idx];
  endfunction

  // shared edge events
  logic sclk_rise, sclk_fall, cs_fall, transmit_clock_rise, rclk_rise, rclk_fall, ref_rise, pwr_rise;
  logic host_mode, edge_sel;
  assign sclk_rise = rose(sy, sy_prev, `LXCS_SY_SCLK);
  assign sclk_fall = fell(sy, sy_prev, `LXCS_SY_SCLK);
  assign cs_fall = fell(sy, sy_prev, `LXCS_SY_CS_N);
  assign transmit_clock_rise = rose(sy, sy_prev, `LXCS_SY_TRANSMIT_CLOCK);
  assign rclk_rise = rose(sy, sy_prev, `LXCS_SY_RCLK);
  assign rclk_fall = fell(sy, sy_prev, `LXCS_SY_RCLK);
  // crystal absent or grounded: the master clock stands in as receive reference
  assign ref_rise = sy[`LXCS_SY_XTAL_OK] ? rose(sy, sy_prev, `LXCS_SY_XTAL)
                                          : rose(sy, sy_prev, `LXCS_SY_MCLK);
  assign pwr_rise = rose(sy, sy_prev, `LXCS_SY_PWR);
  assign host_mode = sy[`LXCS_SY_MODE];
  assign edge_sel = sy[`LXCS_SY_EDGE];

  // serial port state
  lxcs_sport_e phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  lxcs_byte_t cmd, next_cmd;
  lxcs_byte_t data, next_data;
  lxcs_byte_t out_shift, next_out_shift;
  logic reading, next_reading;
  logic serial_out, next_sdo;
  logic sdo_oe, next_sdo_oe;
  logic wr_commit;
  lxcs_byte_t wr_data;
  lxcs_byte_t cmd_now;
  lxcs_byte_t status;

  // control, reset and data path state
  lxcs_byte_t ctrl, next_ctrl;
  logic [3:0] hw_cnt, next_hw_cnt;
  logic hw_armed, next_hw_armed;
  logic [20:0] rst_cnt, next_rst_cnt;
  logic busy, next_busy;
  logic [15:0] tx_cal, next_tx_cal;
  logic [15:0] rx_cal, next_rx_cal;
  logic mark_odd, next_mark_odd;
  logic line_p, next_line_p, line_n, next_line_n;
  logic rxo_p, next_rxo_p, rxo_n, next_rxo_n;
  logic far_eff, near_eff, marks_eff, both_pins, rst_start;

  assign cmd_now = {sy[`LXCS_SY_SDI], cmd[7:1]};
  assign wr_data = {sy[`LXCS_SY_SDI], data[7:1]};
  assign status = {busy, o_tx_cal_done, o_rx_cal_done, host_mode, 1'b0,
                   marks_eff, far_eff, near_eff};
  assign wr_commit = (phase == LXCS_SP_DATA) && sclk_rise && (bit_cnt == `LXCS_BIT_LAST)
                     && !reading && !sy[`LXCS_SY_CS_N];

  always_comb
  begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_cmd = cmd;
    next_data = data;
    next_out_shift = out_shift;
    next_reading = reading;
    next_sdo = serial_out;
    next_sdo_oe = sdo_oe;
    if (sy[`LXCS_SY_CS_N] || !host_mode)
    begin
      next_phase = LXCS_SP_IDLE;
      next_sdo_oe = 1'b0;
      next_reading = 1'b0;
    end
    else if (cs_fall)
    begin
      next_phase = LXCS_SP_CMD;
      next_bit_cnt = 3'h0;
    end
    else
    begin
      unique case (phase)
        LXCS_SP_IDLE: ;
        LXCS_SP_CMD:
          if (sclk_rise)
          begin
            next_cmd = cmd_now;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `LXCS_BIT_LAST)
            begin
              // command byte done, data byte follows
              if (!cmd_now[`LXCS_CMD_A4_BIT])
                next_phase = LXCS_SP_SKIP;
              else
              begin
                next_phase = LXCS_SP_DATA;
                next_reading = cmd_now[`LXCS_CMD_RW_BIT];
                next_sdo_oe = cmd_now[`LXCS_CMD_RW_BIT];
                if (cmd_now[`LXCS_CMD_RW_BIT] && !edge_sel)
                begin
                  next_sdo = status[0];
                  next_out_shift = status >> 1;
                end
                else
                  next_out_shift = status;
              end
            end
          end
        LXCS_SP_DATA:
        begin
          if (sclk_rise)
          begin
            next_data = wr_data;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `LXCS_BIT_LAST)
              next_phase = LXCS_SP_SKIP;
          end
          // output bit changes on the edge opposite the one it is valid at
          if (reading && (edge_sel ? sclk_fall : sclk_rise))
          begin
            next_sdo = out_shift[0];
            next_out_shift = out_shift >> 1;
          end
        end
        LXCS_SP_SKIP:
          if (reading && (edge_sel ? sclk_fall : sclk_rise))
            next_sdo_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      phase <= LXCS_SP_IDLE;
      bit_cnt <= 3'h0;
      cmd <= 8'h00;
      data <= 8'h00;
      out_shift <= 8'h00;
      reading <= 1'b0;
      serial_out <= 1'b0;
      sdo_oe <= 1'b0;
      sy_prev <= '0;
    end
    else
    begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      cmd <= next_cmd;
      data <= next_data;
      out_shift <= next_out_shift;
      reading <= next_reading;
      serial_out <= next_sdo;
      sdo_oe <= next_sdo_oe;
      sy_prev <= sy;
    end
  end

  assign both_pins = sy[`LXCS_SY_FAR] && sy[`LXCS_SY_NEAR];
  assign far_eff = host_mode ? ctrl[`LXCS_CTRL_FAR] : sy[`LXCS_SY_FAR];
  assign near_eff = host_mode ? ctrl[`LXCS_CTRL_NEAR] : sy[`LXCS_SY_NEAR];
  assign marks_eff = (host_mode ? ctrl[`LXCS_CTRL_MARKS] : sy[`LXCS_SY_MARKS])
                     && !far_eff;
  // the reset fires when the qualified request is let go, not while it is held
  assign rst_start = pwr_rise
    || (host_mode && wr_commit && wr_data[`LXCS_CTRL_FAR] && wr_data[`LXCS_CTRL_NEAR])
    || (!host_mode && hw_armed && !both_pins);

  always_comb
  begin
    next_ctrl = ctrl;
    next_hw_cnt = hw_cnt;
    next_hw_armed = hw_armed;
    next_rst_cnt = rst_cnt;
    next_busy = busy;
    next_tx_cal = tx_cal;
    next_rx_cal = rx_cal;
    next_mark_odd = mark_odd;
    next_line_p = line_p;
    next_line_n = line_n;
    next_rxo_p = rxo_p;
    next_rxo_n = rxo_n;
    if (!host_mode && both_pins)
    begin
      if (hw_cnt != 4'(`LXCS_HWRST_CYCLES))
        next_hw_cnt = hw_cnt + 4'h1;
      else
        next_hw_armed = 1'b1;
    end
    else
    begin
      next_hw_cnt = 4'h0;
      next_hw_armed = 1'b0;
    end
    if (host_mode && wr_commit)
      next_ctrl = wr_data;
    if (rst_start)
    begin
      next_ctrl = `LXCS_CTRL_RESET;
      next_busy = 1'b1;
      next_rst_cnt = 21'(RESET_CYCLES - 1);
      next_tx_cal = 16'h0000;
      next_rx_cal = 16'h0000;
      next_mark_odd = 1'b0;
      next_line_p = 1'b0;
      next_line_n = 1'b0;
      next_rxo_p = 1'b0;
      next_rxo_n = 1'b0;
    end
    else if (busy)
    begin
      // the line stays quiet while the delay lines calibrate
      if (rst_cnt == 21'h000000)
        next_busy = 1'b0;
      else
        next_rst_cnt = rst_cnt - 21'h000001;
      if (transmit_clock_rise && tx_cal != `LXCS_CAL_EDGES)
        next_tx_cal = tx_cal + 16'h0001;
      if (ref_rise && rx_cal != `LXCS_CAL_EDGES)
        next_rx_cal = rx_cal + 16'h0001;
    end
    else
    begin
      if (transmit_clock_rise)
      begin
        if (far_eff)
        begin
          next_line_p = sy[`LXCS_SY_RXP];
          next_line_n = sy[`LXCS_SY_RXN];
        end
        else if (marks_eff)
        begin
          // alternate polarity so the all-marks stream stays balanced
          next_line_p = !mark_odd;
          next_line_n = mark_odd;
          next_mark_odd = !mark_odd;
        end
        else
        begin
          next_line_p = sy[`LXCS_SY_TXP];
          next_line_n = sy[`LXCS_SY_TXN];
        end
      end
      // edge_select high: change on rising so data is valid at the falling edge
      if ((host_mode && !edge_sel) ? rclk_fall : rclk_rise)
      begin
        next_rxo_p = near_eff ? sy[`LXCS_SY_TXP] : sy[`LXCS_SY_RXP];
        next_rxo_n = near_eff ? sy[`LXCS_SY_TXN] : sy[`LXCS_SY_RXN];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl <= `LXCS_CTRL_RESET;
      hw_cnt <= 4'h0;
      hw_armed <= 1'b0;
      rst_cnt <= 21'h000000;
      busy <= 1'b0;
      tx_cal <= 16'h0000;
      rx_cal <= 16'h0000;
      mark_odd <= 1'b0;
      line_p <= 1'b0;
      line_n <= 1'b0;
      rxo_p <= 1'b0;
      rxo_n <= 1'b0;
      o_far_loop_active <= 1'b0;
      o_near_loop_active <= 1'b0;
      o_tx_cal_done <= 1'b0;
      o_rx_cal_done <= 1'b0;
      o_rx_ref_xtal <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      hw_cnt <= next_hw_cnt;
      hw_armed <= next_hw_armed;
      rst_cnt <= next_rst_cnt;
      busy <= next_busy;
      tx_cal <= next_tx_cal;
      rx_cal <= next_rx_cal;
      mark_odd <= next_mark_odd;
      line_p <= next_line_p;
      line_n <= next_line_n;
      rxo_p <= next_rxo_p;
      rxo_n <= next_rxo_n;
      o_far_loop_active <= far_eff && !busy;
      o_near_loop_active <= near_eff && !busy;
      o_tx_cal_done <= (next_tx_cal == `LXCS_CAL_EDGES);
      o_rx_cal_done <= (next_rx_cal == `LXCS_CAL_EDGES);
      o_rx_ref_xtal <= sy[`LXCS_SY_XTAL_OK];
    end
  end

  assign o_serial_out = serial_out;
  assign o_serial_out_oe = sdo_oe;
  assign o_port_phase = phase;
  assign o_line_plus = line_p;
  assign o_line_minus = line_n;
  assign o_rx_plus_data = rxo_p;
  assign o_rx_minus_data = rxo_n;
  assign o_reset_busy = busy;
endmodule // lxcs_ctrl

// [verification/lxcs_host_model.sv]
`timescale 1ns/1ps
module lxcs_host_model (
  input logic i_clk,
  input logic i_edge,
  input logic i_sdo,
  input logic i_sdo_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // serial clock stands low between frames; 8 system cycles a period
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] din,
                      output logic [7:0] dout, output logic oe_any);
    logic [15:0] w;
    w = {din, cmd};
    dout = 8'h00;
    oe_any = 1'b0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < 16; i++)
    begin
      o_sdi = w[i];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      // a released output line reads as the opposite of what it last showed
      if (i_edge && i > 7)
        dout[i-8] = i_sdo_oe ? i_sdo : ~i_sdo;
      oe_any |= i_sdo_oe;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
      if (!i_edge && i > 6 && i < 15)
        dout[i-7] = i_sdo_oe ? i_sdo : ~i_sdo;
      oe_any |= i_sdo_oe;
    end
    // data line flips to the opposite of its last bit after the frame
    o_sdi = ~o_sdi;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // lxcs_host_model

// [verification/lxcs_ctrl_checker.sv]
`timescale 1ns/1ps
module lxcs_ctrl_checker #(
  parameter int unsigned RESET_CYCLES = 100
) (
  input logic i_clk_sys,
  input logic i_resetn,
  input logic i_mode,
  input logic i_chip_sel_n,
  input logic i_far_loopback,
  input logic i_near_loopback,
  input logic i_send_all_marks,
  input logic o_serial_out_oe,
  input logic o_line_plus,
  input logic o_line_minus,
  input logic o_far_loop_active,
  input logic o_near_loop_active,
  input logic o_reset_busy
);
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  logic [5:0] mark_cnt;
  logic [5:0] next_mark_cnt;
  logic marks_req;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  assign marks_req = !i_mode && i_send_all_marks && !i_far_loopback && !i_near_loopback;
  // mark count saturates so a long hold never wraps back below the threshold
  always_comb
  begin
    next_busy_cnt = o_reset_busy ? busy_cnt + 32'h1 : 32'h0;
    next_mark_cnt = (marks_req && !o_reset_busy) ? mark_cnt + {5'h00, mark_cnt != 6'h3F} : 6'h00;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy_cnt <= 32'h0;
      mark_cnt <= 6'h00;
    end
    else
    begin
      busy_cnt <= next_busy_cnt;
      mark_cnt <= next_mark_cnt;
    end
  end
  busy_len_a: assert property ($fell(o_reset_busy) |->
    busy_cnt >= RESET_CYCLES && busy_cnt <= RESET_CYCLES + 2) else $error("reset length");
  busy_lines_a: assert property (o_reset_busy [*3] |->
    !o_line_plus && !o_line_minus) else $error("line driven in reset");
  busy_loops_a: assert property (o_reset_busy [*2] |->
    !o_far_loop_active && !o_near_loop_active) else $error("loop on in reset");
  cs_release_a: assert property ((i_chip_sel_n) [*6] |-> !o_serial_out_oe)
    else $error("output driven while deselected");
  hw_quiet_a: assert property ((!i_mode) [*6] |-> !o_serial_out_oe)
    else $error("output driven in pin mode");
  hw_far_a: assert property ((!i_mode && i_far_loopback && !i_near_loopback &&
    !o_reset_busy) [*8] |-> o_far_loop_active) else $error("far loop off");
  hw_near_a: assert property ((!i_mode && i_near_loopback && !i_far_loopback &&
    !o_reset_busy) [*8] |-> o_near_loop_active) else $error("near loop off");
  marks_out_a: assert property (mark_cnt > 6'h1E |-> o_line_plus ^ o_line_minus)
    else $error("no mark sent");
endmodule // lxcs_ctrl_checker
bind lxcs_ctrl lxcs_ctrl_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

// [verification/lxcs_ctrl_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: %h expected %h", $time, a, e); \
    end \
  end
module lxcs_ctrl_tb_top;
  logic clk = 0, resetn = 0, pg = 0, mode = 1, es = 0, far = 0, near = 0, marks = 0;
  logic transmit_clock = 0, rclk = 0, xclk = 0, mclk = 0, txp = 0, txn = 0, rxp = 0, rxn = 0, xp = 1;
  logic sclk, cs_n, serial_in, serial_out, oe, lp, lm, orp, orn, fa, na, busy, tcd, rcd, rref;
  logic [1:0] ph;
  logic [7:0] wd [4] = '{8'h01, 8'h02, 8'h06, 8'h04};
  logic [7:0] st [4] = '{8'h71, 8'h72, 8'h72, 8'h74};
  int num_errors = 0, cmp_count = 0, k = 0;
  lxcs_ctrl #(.RESET_CYCLES(3000)) dut (
    .i_clk_sys(clk), .i_resetn(resetn), .i_power_good(pg), .i_mode(mode), .i_sclk(sclk),
    .i_chip_sel_n(cs_n), .i_serial_in(serial_in), .i_edge_select(es), .i_far_loopback(far),
    .i_near_loopback(near), .i_send_all_marks(marks), .i_transmit_clock(transmit_clock),
    .i_tx_plus_data(txp), .i_tx_minus_data(txn), .i_rx_clock(rclk), .i_rx_plus_data(rxp),
    .i_rx_minus_data(rxn), .i_xtal_clock(xclk), .i_master_clock(mclk), .i_xtal_present(xp),
    .o_serial_out(serial_out), .o_serial_out_oe(oe), .o_port_phase(ph), .o_line_plus(lp),
    .o_line_minus(lm), .o_rx_plus_data(orp), .o_rx_minus_data(orn), .o_far_loop_active(fa),
    .o_near_loop_active(na), .o_reset_busy(busy), .o_tx_cal_done(tcd), .o_rx_cal_done(rcd),
    .o_rx_ref_xtal(rref)
  );
  lxcs_host_model host (
    .i_clk(clk), .i_edge(es), .i_sdo(serial_out), .i_sdo_oe(oe), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdi(serial_in)
  );
  always #12.5 clk = ~clk;
  // reference clocks fast enough to reach the calibration count within one reset cycle
  always @(negedge clk)
  begin
    k <= k + 1;
    transmit_clock <= (k % 10) < 5;
    rclk <= (k % 16) < 8;
    xclk <= (k % 6) < 3;
    mclk <= (k % 8) < 4;
  end
  task automatic stop_test;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(busy, v)
  endtask
  task automatic xfer_chk(input logic [7:0] cmd, input logic [7:0] din,
                          output logic [7:0] q, output logic a);
    fork
      host.xfer(cmd, din, q, a);
      begin
        // by now the command byte is decoded and the data byte is under way
        repeat (70) @(negedge clk);
        `CHK(ph, mode ? (cmd[4] ? 2'h2 : 2'h3) : 2'h0)
      end
    join
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    xfer_chk(8'h10, d, q, a);
    `CHK(a, 1'b0)
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    logic [7:0] q;
    logic a;
    xfer_chk(cmd, 8'h00, q, a);
    `CHK(a, cmd[4] & mode)
    if (a === 1'b1)
      `CHK(q, e)
  endtask
  initial
  begin
    repeat (20000) @(negedge clk);
    num_errors++;
    stop_test;
  end
  initial
  begin
    repeat (16) @(negedge clk);
    resetn = 1;
    repeat (4) @(negedge clk);
    pg = 1;
    wait_busy(1);
    wait_busy(0);
    `CHK({tcd, rcd, rref}, 3'h7)
    $display("power-up test done");
    for (int i = 0; i < 4; i++)
    begin
      es = i[0];
      wr(wd[i]);
      `CHK({fa, na}, wd[i][1:0])
      rd(8'h12, st[i]);
    end
    rd(8'h02, 8'h00);
    $display("host port test done");
    // new receive data lands just after a rising receive clock edge
    for (int i = 0; i < 2; i++)
    begin
      es = i[0];
      @(posedge rclk);
      @(negedge clk);
      rxp = ~rxp;
      repeat (12) @(negedge clk);
      `CHK(orp, rxp ^ es)
    end
    rxp = 0;
    $display("receive timing test done");
    xp = 0;
    wr(8'h03);
    wait_busy(1);
    wait_busy(0);
    `CHK(rref, 1'b0)
    rd(8'h12, 8'h70);
    $display("host reset test done");
    mode = 0;
    rd(8'h12, 8'h00);
    far = 1;
    marks = 1;
    rxp = 1;
    txp = 1;
    txn = 1;
    repeat (40) @(negedge clk);
    `CHK({fa, lp, lm}, 3'b110)
    far = 0;
    repeat (40) @(negedge clk);
    `CHK(lp ^ lm, 1'b1)
    marks = 0;
    near = 1;
    repeat (40) @(negedge clk);
    `CHK({na, orp, orn}, 3'b111)
    $display("pin control test done");
    far = 1;
    repeat (12) @(negedge clk);
    `CHK(busy, 1'b0)
    far = 0;
    near = 0;
    wait_busy(1);
    wait_busy(0);
    $display("pin reset test done");
    stop_test;
  end
endmodule // lxcs_ctrl_tb_top
